//--- verilog/key_event_flag_register.sv
/*
  Read-to-clear key event flag register with per-key qualification filters
  and the key detection enable bit.
  Assumes a serial port front end that issues one-cycle read requests and
  write strobes for the enable bit, and an accessory removal pulse.
*/
// Contract
// - bit 7 sets after key four release outlasts release interval
// - bit 6 sets after key four press outlasts press interval
// - key three: bit 5 release, bit 4 press, each with its interval
// - key two: bit 3 release, bit 2 press, each with its interval
// - bit 1 marks key one release after release interval
// - a host read of the register clears the flags it returned, except any set again while clearing
// - writing zero to key detect enable clears every flag
// - accessory removal drops the enable bit and clears all flags
// - a press flag setting clears the same key's release flag
// - clearing after a read takes 200 us; quick rereads see old flags
// - detection keeps running while flags wait for service
module key_event_flag_register #(
  parameter int unsigned CLEAR_CYCLES        = key_event_pkg::CLEAR_CYCLES,
  parameter int unsigned PRESS_STEP_CYCLES   = key_event_pkg::PRESS_STEP_CYCLES,
  parameter int unsigned RELEASE_STEP_CYCLES = key_event_pkg::RELEASE_STEP_CYCLES
) (
  // clock and reset
  input  logic                                      i_sys_clk,
  input  logic                                      i_srst,
  // register read
  input  key_event_pkg::rd_req_t                    i_rd,
  output key_event_pkg::key_flags_t                 o_rd_data,
  output logic                                      o_rd_valid,
  // key detection enable
  input  logic                                      i_enable_wr,
  input  logic                                      i_enable_wdata,
  input  logic                                      i_removal,
  output logic                                      o_key_detect_enable,
  // filter settings
  input  logic [key_event_pkg::PRESS_SEL_W-1:0]     i_press_filter_interval,
  input  logic [key_event_pkg::RELEASE_SEL_W-1:0]   i_release_filter_interval,
  // key detector levels
  input  logic [key_event_pkg::KEYS-1:0]            i_key_down,
  // live flags
  output key_event_pkg::key_flags_t                 o_key_flags
);

  localparam logic [key_event_pkg::CLR_W-1:0] CLR_LAST = key_event_pkg::CLR_W'(CLEAR_CYCLES - 1);

  key_event_pkg::key_flags_t       flags_reg;
  key_event_pkg::key_flags_t       flags_next;
  key_event_pkg::key_flags_t       rd_data_reg;
  key_event_pkg::key_flags_t       clr_mask_reg;
  key_event_pkg::key_flags_t       clr_mask_next;
  key_event_pkg::key_flags_t       set_vec;
  key_event_pkg::key_flags_t       rel_kill;
  key_event_pkg::key_flags_t       clr_kill;
  key_event_pkg::key_flags_t       clr_gone;
  key_event_pkg::key_flags_t       kept_vec;
  key_event_pkg::clr_state_t       state_reg;
  key_event_pkg::clr_state_t       state_next;
  logic [key_event_pkg::CLR_W-1:0] clr_cnt_reg;
  logic [key_event_pkg::CLR_W-1:0] clr_cnt_next;
  logic                            enable_reg;
  logic                            enable_next;
  logic                            rd_valid_reg;
  logic [key_event_pkg::KEYS-1:0]  press_evt;
  logic [key_event_pkg::KEYS-1:0]  release_evt;
  logic [key_event_pkg::CNT_W-1:0] press_cycles;
  logic [key_event_pkg::CNT_W-1:0] release_cycles;

  assign press_cycles   = key_event_pkg::interval_cycles(i_press_filter_interval, PRESS_STEP_CYCLES);
  assign release_cycles = key_event_pkg::interval_cycles({1'b0, i_release_filter_interval}, RELEASE_STEP_CYCLES);

  // filters free running
  // detection depends only on the enable bit, never on pending flags
  for (genvar k = 0; k < key_event_pkg::KEYS; k++) begin : g_key
    key_filter u_filter (
      .i_sys_clk        (i_sys_clk),
      .i_srst           (i_srst),
      .i_enable         (enable_reg),
      .i_press_cycles   (press_cycles),
      .i_release_cycles (release_cycles),
      .i_key_down       (i_key_down[k]),
      .o_press_evt      (press_evt[k]),
      .o_release_evt    (release_evt[k])
    );
  end

  assign set_vec  = key_event_pkg::pack_events(press_evt, release_evt);
  assign rel_kill = key_event_pkg::pack_events(4'h0, press_evt);

  wire rd_hit    = i_rd.strobe && (i_rd.addr == key_event_pkg::KEY_FLAGS_OFFSET);
  wire clr_start = rd_hit && (state_reg == key_event_pkg::CLR_IDLE) && enable_reg;
  wire clr_done  = (state_reg == key_event_pkg::CLR_BUSY) && (clr_cnt_reg == CLR_LAST);
  wire clr_run   = (state_reg == key_event_pkg::CLR_BUSY) && !clr_done && enable_reg;

  assign clr_kill = clr_done ? clr_mask_reg : key_event_pkg::FLAGS_RESET;
  // fresh events leave the mask
  // a set arriving on the clearing edge wins because set_vec is or-ed in last
  assign clr_gone      = clr_mask_reg & ~set_vec;
  assign clr_mask_next = clr_start ? (flags_reg & ~set_vec) : (clr_run ? clr_gone : key_event_pkg::FLAGS_RESET);
  assign kept_vec   = flags_reg & ~rel_kill & ~clr_kill;
  assign flags_next = enable_reg ? (kept_vec | set_vec) : key_event_pkg::FLAGS_RESET;
  assign enable_next = i_removal ? 1'h0 : (i_enable_wr ? i_enable_wdata : enable_reg);

  // clearing delay timer
  // a read during the delay returns the flags but does not restart it
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      key_event_pkg::CLR_IDLE: begin
        if (clr_start) begin
          state_next = key_event_pkg::CLR_BUSY;
        end
      end
      key_event_pkg::CLR_BUSY: begin
        if (clr_done || !enable_reg) begin
          state_next = key_event_pkg::CLR_IDLE;
        end
      end
      default: begin
        state_next = key_event_pkg::CLR_IDLE;
      end
    endcase
  end

  assign clr_cnt_next = clr_run ? clr_cnt_reg + 1'b1 : {key_event_pkg::CLR_W{1'b0}};

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      flags_reg    <= key_event_pkg::FLAGS_RESET;
      clr_mask_reg <= key_event_pkg::FLAGS_RESET;
      state_reg    <= key_event_pkg::CLR_IDLE;
      clr_cnt_reg  <= {key_event_pkg::CLR_W{1'b0}};
      enable_reg   <= key_event_pkg::ENABLE_RESET;
    end else begin
      flags_reg    <= flags_next;
      clr_mask_reg <= clr_mask_next;
      state_reg    <= state_next;
      clr_cnt_reg  <= clr_cnt_next;
      enable_reg   <= enable_next;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      rd_data_reg  <= key_event_pkg::FLAGS_RESET;
      rd_valid_reg <= 1'h0;
    end else begin
      rd_data_reg  <= rd_hit ? flags_reg : rd_data_reg;
      rd_valid_reg <= rd_hit;
    end
  end

  assign o_rd_data           = rd_data_reg;
  assign o_rd_valid          = rd_valid_reg;
  assign o_key_detect_enable = enable_reg;
  assign o_key_flags         = flags_reg;

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_srst);

  property p_k4_release;
    (enable_reg && release_evt[3]) |=> flags_reg.k4_release;
  endproperty
  a_k4_release: assert property (p_k4_release) else $error("key four release flag missed");

  property p_k4_press;
    (enable_reg && press_evt[3]) |=> flags_reg.k4_press;
  endproperty
  a_k4_press: assert property (p_k4_press) else $error("key four press flag missed");

  property p_k3_flags;
    (enable_reg && press_evt[2]) |=> (flags_reg.k3_press && !flags_reg.k3_release);
  endproperty
  a_k3_flags: assert property (p_k3_flags) else $error("key three flags wrong");

  property p_k2_release;
    (enable_reg && release_evt[1]) |=> (flags_reg.k2_release && (flags_reg.k2_press == $past(kept_vec.k2_press)));
  endproperty
  a_k2_release: assert property (p_k2_release) else $error("key two release flag wrong");

  property p_k1_release;
    (enable_reg && release_evt[0]) |=> flags_reg.k1_release;
  endproperty
  a_k1_release: assert property (p_k1_release) else $error("key one release flag missed");

  property p_read_clear;
    clr_done |=> ((flags_reg & $past(clr_gone)) == 8'h00);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read flags not cleared");

  property p_disable_clear;
    !enable_reg |=> (flags_reg == 8'h00);
  endproperty
  a_disable_clear: assert property (p_disable_clear) else $error("flags survive disable");

  property p_removal;
    i_removal |=> (!o_key_detect_enable ##1 (o_key_flags == 8'h00));
  endproperty
  a_removal: assert property (p_removal) else $error("removal did not clear");

  property p_press_kills_release;
    (enable_reg && press_evt[3]) |=> !flags_reg.k4_release;
  endproperty
  a_press_kills_release: assert property (p_press_kills_release) else $error("release flag kept");

  property p_read_data;
    o_rd_valid |-> (o_rd_data == $past(flags_reg));
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data not the flags");

  property p_clear_delay;
    clr_start |=> ((state_reg == key_event_pkg::CLR_BUSY) && (o_key_flags == ($past(kept_vec) | $past(set_vec))));
  endproperty
  a_clear_delay: assert property (p_clear_delay) else $error("flags cleared too early");

  property p_detect_busy;
    ((state_reg == key_event_pkg::CLR_BUSY) && enable_reg && press_evt[0]) |=> flags_reg.k1_press;
  endproperty
  a_detect_busy: assert property (p_detect_busy) else $error("event lost while clearing");

  property p_keep_new;
    (clr_done && enable_reg) |=> ((flags_reg & $past(set_vec)) == $past(set_vec));
  endproperty
  a_keep_new: assert property (p_keep_new) else $error("event lost at clear");

  c_read_hit: cover property (clr_start);
  c_clear_done: cover property (clr_done);
  c_removal: cover property (i_removal && (flags_reg != 8'h00));
  c_event_while_busy: cover property ((state_reg == key_event_pkg::CLR_BUSY) && (set_vec != 8'h00));

endmodule : key_event_flag_register

//--- common/key_event_pkg.sv
/*
  Shared constants, carriers and helpers for the key event flag register.
  Assumes a 200 MHz core clock and an external serial port that turns a host
  register read into a one-cycle read request.
*/
package key_event_pkg;

  // clock rate and timing, times in their own unit, counts derived
  localparam int unsigned CLK_MHZ             = 200;
  localparam int unsigned CLEAR_TIME_US       = 200;
  localparam int unsigned CLEAR_CYCLES        = CLEAR_TIME_US * CLK_MHZ;
  localparam int unsigned PRESS_STEP_US       = 1000;
  localparam int unsigned PRESS_STEP_CYCLES   = PRESS_STEP_US * CLK_MHZ;
  localparam int unsigned RELEASE_STEP_US     = 1000;
  localparam int unsigned RELEASE_STEP_CYCLES = RELEASE_STEP_US * CLK_MHZ;

  // widths
  localparam int unsigned CNT_W         = 24;
  localparam int unsigned CLR_W         = 16;
  localparam int unsigned ADDR_W        = 8;
  localparam int unsigned PRESS_SEL_W   = 2;
  localparam int unsigned RELEASE_SEL_W = 1;
  localparam int unsigned KEYS          = 4;

  // register map and reset values
  localparam logic [ADDR_W-1:0] KEY_FLAGS_OFFSET = 8'h02;
  localparam logic [7:0]        FLAGS_RESET      = 8'h00;
  localparam logic              ENABLE_RESET     = 1'h0;

  typedef struct packed {
    logic k4_release;
    logic k4_press;
    logic k3_release;
    logic k3_press;
    logic k2_release;
    logic k2_press;
    logic k1_release;
    logic k1_press;
  } key_flags_t;

  typedef struct packed {
    logic              strobe;
    logic [ADDR_W-1:0] addr;
  } rd_req_t;

  typedef enum logic [1:0] {
    CLR_IDLE = 2'h1,
    CLR_BUSY = 2'h2
  } clr_state_t;

  // interleave per-key press and release bits into the register layout
  function automatic key_flags_t pack_events(input logic [KEYS-1:0] press, input logic [KEYS-1:0] rel);
    pack_events = {rel[3], press[3], rel[2], press[2], rel[1], press[1], rel[0], press[0]};
  endfunction : pack_events

  // filter length in cycles for a setting code
  function automatic logic [CNT_W-1:0] interval_cycles(input logic [1:0] code, input int unsigned step);
    interval_cycles = CNT_W'((32'(code) + 32'h1) * step);
  endfunction : interval_cycles

endpackage : key_event_pkg

//--- verilog/key_filter.sv
/*
  One key's press and release qualification filter.
  Assumes the key detector level is synchronous to the core clock and that the
  interval counts stay constant while a key transition is being timed.
*/
module key_filter (
  // clock and reset
  input  logic                             i_sys_clk,
  input  logic                             i_srst,
  // control and settings
  input  logic                             i_enable,
  input  logic [key_event_pkg::CNT_W-1:0]  i_press_cycles,
  input  logic [key_event_pkg::CNT_W-1:0]  i_release_cycles,
  // key level
  input  logic                             i_key_down,
  // qualified events
  output logic                             o_press_evt,
  output logic                             o_release_evt
);

  logic                            stable_reg;
  logic                            stable_next;
  logic [key_event_pkg::CNT_W-1:0] cnt_reg;
  logic [key_event_pkg::CNT_W-1:0] cnt_next;
  logic                            press_reg;
  logic                            release_reg;

  wire                             differs = (i_key_down != stable_reg);
  wire [key_event_pkg::CNT_W-1:0]  limit   = stable_reg ? i_release_cycles : i_press_cycles;
  // a change must outlast the interval: fires on the cycle after it has held that long
  wire                             expire  = differs && (cnt_reg == limit);

  assign stable_next = i_enable && (expire ? !stable_reg : stable_reg);
  assign cnt_next    = (!i_enable || !differs || expire) ? {key_event_pkg::CNT_W{1'b0}} : cnt_reg + 1'b1;

  always_ff @(posedge i_sys_clk) begin
    if (i_srst) begin
      stable_reg  <= 1'h0;
      cnt_reg     <= {key_event_pkg::CNT_W{1'b0}};
      press_reg   <= 1'h0;
      release_reg <= 1'h0;
    end else begin
      stable_reg  <= stable_next;
      cnt_reg     <= cnt_next;
      press_reg   <= i_enable && expire && !stable_reg;
      release_reg <= i_enable && expire && stable_reg;
    end
  end

  assign o_press_evt   = press_reg;
  assign o_release_evt = release_reg;

endmodule : key_filter

//--- test/key_host_model.sv
/*
  Host side model: issues register reads and collects the answer.
  Assumes the block answers a read at the taking edge itself, valid by the next falling edge.
*/
module key_host_model (
  // clock
  input  logic                       i_sys_clk,
  // read answer
  input  logic                       i_rd_valid,
  input  key_event_pkg::key_flags_t  i_rd_data,
  // read request
  output key_event_pkg::rd_req_t     o_rd
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_rd = '{strobe: 1'h0, addr: 8'h5A};

  // reads may follow closely
  // a fast reread sees stale flags, so nothing here waits on clearing
  task automatic read_reg(input logic [7:0] addr, output key_event_pkg::key_flags_t data, output logic got);
    int i;
    got = 1'h0;
    data = '0;
    o_rd.strobe = 1'h1;
    o_rd.addr = addr;
    @(negedge i_sys_clk);
    o_rd.strobe = 1'h0;
    // released address shows a changed value, not the old one
    o_rd.addr = ~addr;
    for (i = 0; i < 3 && !got; i++) begin
      if (i_rd_valid === 1'h1) begin
        got = 1'h1;
        data = i_rd_data;
      end
      @(negedge i_sys_clk);
    end
  endtask : read_reg
endmodule : key_host_model

//--- test/key_event_flag_register_tb_top.sv
/*
  Self-checking bench for the key event flag register.
  Assumes shortened clear and filter counts; inputs change at falling edges.
*/
module key_event_flag_register_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CLR  = 20;
  localparam int unsigned STEP = 4;

  logic                      i_sys_clk = 1'h0;
  logic                      i_srst = 1'h1;
  key_event_pkg::rd_req_t    rd;
  key_event_pkg::key_flags_t rd_data;
  key_event_pkg::key_flags_t flags;
  key_event_pkg::key_flags_t got;
  logic                      rd_valid;
  logic                      ok;
  logic                      detect_en;
  logic                      enable_wr = 1'h0;
  logic                      enable_wdata = 1'h0;
  logic                      removal = 1'h0;
  logic [1:0]                press_code = 2'h0;
  logic [0:0]                rel_code = 1'h0;
  logic [3:0]                keys = 4'h0;
  int                        miscompares = 0;
  int                        checks = 0;

  always #2.5 i_sys_clk = ~i_sys_clk;

  key_event_flag_register #(
    .CLEAR_CYCLES       (CLR),
    .PRESS_STEP_CYCLES  (STEP),
    .RELEASE_STEP_CYCLES(STEP)
  ) u_key_event_flag_register (
    .i_sys_clk                (i_sys_clk),
    .i_srst                   (i_srst),
    .i_rd                     (rd),
    .o_rd_data                (rd_data),
    .o_rd_valid               (rd_valid),
    .i_enable_wr              (enable_wr),
    .i_enable_wdata           (enable_wdata),
    .i_removal                (removal),
    .o_key_detect_enable      (detect_en),
    .i_press_filter_interval  (press_code),
    .i_release_filter_interval(rel_code),
    .i_key_down               (keys),
    .o_key_flags              (flags)
  );

  key_host_model u_key_host_model (
    .i_sys_clk (i_sys_clk),
    .i_rd_valid(rd_valid),
    .i_rd_data (rd_data),
    .o_rd      (rd)
  );

  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : check

  task automatic cycles(input int n);
    repeat (n) @(negedge i_sys_clk);
  endtask : cycles

  task automatic set_enable(input logic v);
    enable_wr = 1'h1;
    enable_wdata = v;
    cycles(1);
    enable_wr = 1'h0;
    cycles(2);
  endtask : set_enable

  // a change must outlast n cycles; the flag shows exactly one edge after the expiry edge
  task automatic key_event(input int k, input logic down, input int n);
    int b;
    b = 2 * k + (down ? 0 : 1);
    keys[k] = down;
    cycles(n + 1);
    check({7'h0, flags[b]}, 8'h00);
    cycles(1);
    check({7'h0, flags[b]}, 8'h01);
  endtask : key_event

  task automatic t_reset();
    check(flags, 8'h00);
    check({7'h0, detect_en}, 8'h00);
    check({7'h0, rd_valid}, 8'h00);
  endtask : t_reset

  // every press code, one per key
  task automatic t_press_all();
    set_enable(1'h1);
    check({7'h0, detect_en}, 8'h01);
    for (int k = 0; k < 4; k++) begin
      press_code = 2'(k);
      key_event(k, 1'h1, (k + 1) * STEP);
    end
    check(flags, 8'h55);
  endtask : t_press_all

  task automatic t_release_all();
    for (int k = 0; k < 4; k++) begin
      rel_code = 1'(k);
      key_event(k, 1'h0, (k % 2 + 1) * STEP);
    end
    check(flags, 8'hFF);
  endtask : t_release_all

  // a press during clearing must survive the clear
  task automatic t_read_clear();
    press_code = 2'h0;
    u_key_host_model.read_reg(8'h02, got, ok);
    check(got, 8'hFF);
    check({7'h0, ok}, 8'h01);
    keys[0] = 1'h1;
    check(flags, 8'hFF);
    u_key_host_model.read_reg(8'h02, got, ok);
    check(got, 8'hFF);
    cycles(CLR + 4);
    check(flags, 8'h01);
    u_key_host_model.read_reg(8'h02, got, ok);
    check(got, 8'h01);
    cycles(CLR + 4);
    check(flags, 8'h00);
  endtask : t_read_clear

  task automatic t_press_clears_release();
    rel_code = 1'h0;
    key_event(3, 1'h1, STEP);
    u_key_host_model.read_reg(8'h02, got, ok);
    check(got, 8'h40);
    cycles(CLR + 4);
    key_event(3, 1'h0, STEP);
    check(flags, 8'h80);
    key_event(3, 1'h1, STEP);
    check(flags, 8'h40);
  endtask : t_press_clears_release

  task automatic t_unmapped();
    u_key_host_model.read_reg(8'h03, got, ok);
    check({7'h0, ok}, 8'h00);
    check(flags, 8'h40);
  endtask : t_unmapped

  task automatic t_disable();
    set_enable(1'h0);
    check(flags, 8'h00);
    check({7'h0, detect_en}, 8'h00);
    u_key_host_model.read_reg(8'h02, got, ok);
    check(got, 8'h00);
  endtask : t_disable

  // keys one and four still held, so enabling catches two fresh presses
  task automatic t_removal();
    set_enable(1'h1);
    cycles(12);
    check(flags, 8'h41);
    // removal must beat an enable write in the same cycle
    removal = 1'h1;
    enable_wr = 1'h1;
    enable_wdata = 1'h1;
    cycles(1);
    removal = 1'h0;
    enable_wr = 1'h0;
    cycles(2);
    check({7'h0, detect_en}, 8'h00);
    check(flags, 8'h00);
  endtask : t_removal

  initial begin
    cycles(12);
    i_srst = 1'h0;
    cycles(1);
    t_reset();
    t_press_all();
    t_release_all();
    t_read_clear();
    t_press_clears_release();
    t_unmapped();
    t_disable();
    t_removal();
    conclude();
  end

  // whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    miscompares++;
    conclude();
  end
endmodule : key_event_flag_register_tb_top
